// [scis_consts.svh]
`ifndef SCIS_CONSTS_SVH
`define SCIS_CONSTS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SCIS_CLK_KHZ        125000
`define SCIS_ENC_READY_MS   400
`define SCIS_ENC_SERIAL_MS  100

// ----------------------------------------------------------------------------
// apb map (byte addresses) and register indices
// ----------------------------------------------------------------------------
`define SCIS_AW             8
`define SCIS_NUM_CFG        9
`define SCIS_A_SETUP1       8'h00
`define SCIS_A_SETUP2       8'h04
`define SCIS_A_LOCK_SPEED   8'h08
`define SCIS_A_FWD_CLAMP    8'h0C
`define SCIS_A_REV_CLAMP    8'h10
`define SCIS_A_SPEED1       8'h14
`define SCIS_A_SPEED2       8'h18
`define SCIS_A_SPEED3       8'h1C
`define SCIS_A_MODE_CFG     8'h20
`define SCIS_A_STATUS       8'h24
`define SCIS_IX_SETUP1      4'h0
`define SCIS_IX_SETUP2      4'h1
`define SCIS_IX_LOCK_SPEED  4'h2
`define SCIS_IX_FWD_CLAMP   4'h3
`define SCIS_IX_REV_CLAMP   4'h4
`define SCIS_IX_SPEED1      4'h5
`define SCIS_IX_SPEED2      4'h6
`define SCIS_IX_SPEED3      4'h7
`define SCIS_IX_MODE_CFG    4'h8
`define SCIS_IX_STATUS      4'h9

// ----------------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------------
`define SCIS_S1_RUN_BYPASS  0
`define SCIS_S1_FWD_OFF     2
`define SCIS_S1_REV_OFF     3
`define SCIS_S1_STOP_A      6
`define SCIS_S1_STOP_B      8
`define SCIS_S1_STOP_C      9
`define SCIS_S1_FN_A        10
`define SCIS_S1_FN_B        11
`define SCIS_S2_SPEED_SEL   2
`define SCIS_MC_TORQUE1     2'b01
`define SCIS_MC_TORQUE2     2'b10
`define SCIS_RST_ZERO       16'h0000
`define SCIS_RST_CLAMP      16'h0064

`endif

// [scis_pkg.sv]
`default_nettype none

package scis_pkg;

	typedef enum logic [1:0]
	{
		ENC_OFF    = 2'b00,
		ENC_SERIAL = 2'b01,
		ENC_PULSES = 2'b10,
		ENC_NORMAL = 2'b11
	} scis_enc_state_type;

	typedef enum logic [1:0]
	{
		MODE_SPEED    = 2'b00,
		MODE_TORQUE   = 2'b01,
		MODE_POSITION = 2'b10
	} scis_ctrl_mode_type;

	typedef enum logic [2:0]
	{
		FN_GAIN      = 3'b000,
		FN_LOCK      = 3'b001,
		FN_SWITCH    = 3'b010,
		FN_DIRECTION = 3'b011,
		FN_NONE      = 3'b100
	} scis_mf_fn_type;

	// discrete inputs from the host controller
	typedef struct packed
	{
		logic run;
		logic multi_fn;
		logic forward_drive_permit;
		logic reverse_drive_permit;
		logic forward_current_clamp;
		logic reverse_current_clamp;
		logic alarm_reset;
		logic encoder_power_request;
	} scis_ctl_in_type;

	// commands to the power stage, loops and encoder interface
	typedef struct packed
	{
		logic               main_power;
		logic               integral_disable;
		scis_ctrl_mode_type ctrl_mode;
		logic               speed_limit_mode;
		logic               internal_speed_direction;
		logic               internal_speed_active;
		logic [15:0]        internal_speed;
		logic               forward_clamp_on;
		logic               reverse_clamp_on;
		logic [15:0]        forward_clamp_percent;
		logic [15:0]        reverse_clamp_percent;
		logic               forward_blocked;
		logic               reverse_blocked;
		logic [2:0]         stop_method;
		logic               alarm;
		logic               encoder_supply;
		scis_enc_state_type encoder_phase;
	} scis_drive_cmd_type;

endpackage

`default_nettype wire

// [scis_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser; only q_out may be looked at downstream
module scis_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic [WIDTH-1:0] d_in,
	input  wire logic             clk,
	input  wire logic             rst,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= '0;
			q_out  <= '0;
		end
		else
		begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule
`default_nettype wire

// [scis_timer.sv]
`timescale 1ns/1ps
`default_nettype none

// one-shot delay: done rises CYCLES edges after the start edge and stays
module scis_timer #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic clear,
	output logic      done
);

	logic [31:0] count_q;
	logic        run_q;

	// clear dominates start so a supply cut always aborts the sequence
	always_ff @(posedge clk)
	begin
		if (rst || clear)
		begin
			count_q <= 32'h0000_0000;
			run_q   <= 1'b0;
			done    <= 1'b0;
		end
		else if (start)
		begin
			count_q <= 32'h0000_0000;
			run_q   <= 1'b1;
			done    <= 1'b0;
		end
		else if (run_q)
		begin
			if (count_q == 32'(CYCLES - 1))
			begin
				run_q <= 1'b0;
				done  <= 1'b1;
			end
			else
			begin
				count_q <= count_q + 32'h0000_0001;
			end
		end
	end

endmodule
`default_nettype wire

// [scis_top.sv]
// Functional notes
// - main power only while run is asserted or setup1 bit 0 is set; otherwise servo off
// - setup1 bit 0 bypasses run and servo turns on after power-up
// - setup1 bits b,A pick multi-function meaning; speed-select mode makes it direction
// - gain reduction asserted disables the loop integral term
// - position lock below lock speed switches speed control to position hold
// - torque mode II: torque/speed switch asserted selects speed control
// - in torque control the analog speed command acts as speed limit
// - direction input low forward, high reverse at internal speeds
// - forward prohibit honoured if setup1 bit 2 is 0, reverse if bit 3 is 0
// - a direction is permitted only while its permit input is asserted or its setup1 bit (2 forward, 3 reverse) is set
// - blocked motion stops by setup1 bits 6, 8, 9; no alarm raised
// - under torque control bits 6 and 9 pick the stop method; bit 8 is forced to 0
// - setup2 bit 2 clear: shared inputs clamp forward and reverse current
// - clamp values are percent of rated current, 100 means rated
// - setup2 bit 2 set: shared inputs select internal speeds one to three
// - alarm reset input clears the servo alarm state
// - encoder request rising turns on the encoder supply
// - encoder request falling with motor unpowered cuts the encoder supply
// - request falling is ignored while the motor is powered
// - no motor power until request asserted and encoder in normal output
// - after request: serial data, initial pulses, normal output after 400 ms
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scis_consts.svh"

module scis_top #(
	parameter int unsigned ENC_READY_CYCLES  = `SCIS_ENC_READY_MS * `SCIS_CLK_KHZ,
	parameter int unsigned ENC_SERIAL_CYCLES = `SCIS_ENC_SERIAL_MS * `SCIS_CLK_KHZ
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [`SCIS_AW-1:0]          paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire scis_pkg::scis_ctl_in_type    ctl_in,
	input  wire logic                         drive_fault,
	input  wire logic signed [15:0]           motor_speed,
	output var scis_pkg::scis_drive_cmd_type  drive_cmd
);

	import scis_pkg::*;

	scis_ctl_in_type    ctl_s;
	scis_drive_cmd_type cmd_d;
	scis_drive_cmd_type cmd_q;
	scis_enc_state_type enc_st_q;
	scis_ctrl_mode_type mode;
	scis_mf_fn_type     mf_fn;
	logic [15:0]        cfg_q [`SCIS_NUM_CFG];
	logic [15:0]        setup1;
	logic [15:0]        setup2;
	logic [15:0]        status;
	logic [15:0]        speed_mag;
	logic [4:0]         dec;
	logic [1:0]         spd_code;
	logic               sen_prev_q;
	logic               arst_prev_q;
	logic               enc_supply_q;
	logic               alarm_q;
	logic               sen_rise;
	logic               sen_fall;
	logic               arst_rise;
	logic               enc_cut;
	logic               enc_ok;
	logic               run_eff;
	logic               serial_done;
	logic               ready_done;
	logic               wr_en;
	logic               dir_sel;
	logic               torque_cfg;

	// ------------------------------------------------------------------------
	// input synchronisation and edges
	// ------------------------------------------------------------------------

	// every host input crosses two flops before anything decodes it
	scis_sync #(
		.WIDTH ($bits(scis_ctl_in_type))
	) u_sync (
		.d_in  (ctl_in),
		.clk   (clk),
		.rst   (rst),
		.q_out (ctl_s)
	);

	// edge history taken from the synchronised copy only
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sen_prev_q  <= 1'b0;
			arst_prev_q <= 1'b0;
		end
		else
		begin
			sen_prev_q  <= ctl_s.encoder_power_request;
			arst_prev_q <= ctl_s.alarm_reset;
		end
	end

	assign sen_rise  = ctl_s.encoder_power_request & ~sen_prev_q;
	assign sen_fall  = ~ctl_s.encoder_power_request & sen_prev_q;
	assign arst_rise = ctl_s.alarm_reset & ~arst_prev_q;

	// ------------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------------

	// address to {hit, index}; shared by the read and write paths
	function automatic logic [4:0] addr_decode(input logic [`SCIS_AW-1:0] a);
		logic [4:0] r;
		r = {1'b0, `SCIS_IX_SETUP1};
		unique case (a)
			`SCIS_A_SETUP1:     r = {1'b1, `SCIS_IX_SETUP1};
			`SCIS_A_SETUP2:     r = {1'b1, `SCIS_IX_SETUP2};
			`SCIS_A_LOCK_SPEED: r = {1'b1, `SCIS_IX_LOCK_SPEED};
			`SCIS_A_FWD_CLAMP:  r = {1'b1, `SCIS_IX_FWD_CLAMP};
			`SCIS_A_REV_CLAMP:  r = {1'b1, `SCIS_IX_REV_CLAMP};
			`SCIS_A_SPEED1:     r = {1'b1, `SCIS_IX_SPEED1};
			`SCIS_A_SPEED2:     r = {1'b1, `SCIS_IX_SPEED2};
			`SCIS_A_SPEED3:     r = {1'b1, `SCIS_IX_SPEED3};
			`SCIS_A_MODE_CFG:   r = {1'b1, `SCIS_IX_MODE_CFG};
			`SCIS_A_STATUS:     r = {1'b1, `SCIS_IX_STATUS};
			default:            r = {1'b0, `SCIS_IX_SETUP1};
		endcase
		return r;
	endfunction

	// clamps come out of reset at rated current so an unconfigured drive is sane
	function automatic logic [15:0] reset_value(input int idx);
		logic [15:0] v;
		v = `SCIS_RST_ZERO;
		if (idx == int'(`SCIS_IX_FWD_CLAMP) || idx == int'(`SCIS_IX_REV_CLAMP))
		begin
			v = `SCIS_RST_CLAMP;
		end
		return v;
	endfunction

	assign dec     = addr_decode(paddr);
	assign wr_en   = psel & penable & pwrite & dec[4] & (dec[3:0] != `SCIS_IX_STATUS);
	assign pready  = psel & penable;
	assign pslverr = psel & penable & ~dec[4];

	// configuration writes land at the access edge; status is read-only
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < `SCIS_NUM_CFG; i++)
			begin
				cfg_q[i] <= reset_value(i);
			end
		end
		else if (wr_en)
		begin
			cfg_q[dec[3:0]] <= pwdata[15:0];
		end
	end

	assign status = {7'h00, cmd_q.forward_blocked, cmd_q.reverse_blocked, cmd_q.ctrl_mode,
		enc_st_q, enc_supply_q, cmd_q.main_power, alarm_q};

	// read data is captured in the setup cycle, so access needs no wait state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (psel && !penable)
		begin
			if (!dec[4])
			begin
				prdata <= 32'h0000_0000;
			end
			else if (dec[3:0] == `SCIS_IX_STATUS)
			begin
				prdata <= {16'h0000, status};
			end
			else
			begin
				prdata <= {16'h0000, cfg_q[dec[3:0]]};
			end
		end
	end

	assign setup1 = cfg_q[`SCIS_IX_SETUP1];
	assign setup2 = cfg_q[`SCIS_IX_SETUP2];

	// ------------------------------------------------------------------------
	// encoder supply and output sequencing
	// ------------------------------------------------------------------------

	// a falling request while powered is dropped, not deferred
	assign enc_cut = sen_fall & ~cmd_q.main_power;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			enc_supply_q <= 1'b0;
		end
		else if (sen_rise)
		begin
			enc_supply_q <= 1'b1;
		end
		else if (enc_cut)
		begin
			enc_supply_q <= 1'b0;
		end
	end

	scis_timer #(
		.CYCLES (ENC_SERIAL_CYCLES)
	) u_serial_tmr (
		.clk   (clk),
		.rst   (rst),
		.start (sen_rise),
		.clear (enc_cut),
		.done  (serial_done)
	);

	scis_timer #(
		.CYCLES (ENC_READY_CYCLES)
	) u_ready_tmr (
		.clk   (clk),
		.rst   (rst),
		.start (sen_rise),
		.clear (enc_cut),
		.done  (ready_done)
	);

	// serial position, then initial pulses, then normal incremental output
	always_ff @(posedge clk)
	begin
		if (rst || enc_cut)
		begin
			enc_st_q <= ENC_OFF;
		end
		else if (sen_rise)
		begin
			enc_st_q <= ENC_SERIAL;
		end
		else
		begin
			unique case (enc_st_q)
				ENC_OFF:    enc_st_q <= ENC_OFF;
				ENC_SERIAL: enc_st_q <= serial_done ? ENC_PULSES : ENC_SERIAL;
				ENC_PULSES: enc_st_q <= ready_done ? ENC_NORMAL : ENC_PULSES;
				ENC_NORMAL: enc_st_q <= ENC_NORMAL;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// alarm
	// ------------------------------------------------------------------------

	// a fault in the reset cycle wins, so a live fault is never masked
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			alarm_q <= 1'b0;
		end
		else if (drive_fault)
		begin
			alarm_q <= 1'b1;
		end
		else if (arst_rise)
		begin
			alarm_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// mode and command decode
	// ------------------------------------------------------------------------

	assign run_eff    = setup1[`SCIS_S1_RUN_BYPASS] | ctl_s.run;
	assign enc_ok     = ctl_s.encoder_power_request & (enc_st_q == ENC_NORMAL);
	assign dir_sel    = setup2[`SCIS_S2_SPEED_SEL];
	assign torque_cfg = (cfg_q[`SCIS_IX_MODE_CFG][1:0] == `SCIS_MC_TORQUE1) |
		(cfg_q[`SCIS_IX_MODE_CFG][1:0] == `SCIS_MC_TORQUE2);
	assign speed_mag  = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
	assign spd_code   = {ctl_s.reverse_current_clamp, ctl_s.forward_current_clamp};

	// meaning of the multi-function input; b,A = 1,0 is unassigned
	always_comb
	begin
		mf_fn = FN_NONE;
		if (dir_sel)
		begin
			mf_fn = FN_DIRECTION;
		end
		else
		begin
			unique case ({setup1[`SCIS_S1_FN_B], setup1[`SCIS_S1_FN_A]})
				2'b00:   mf_fn = FN_GAIN;
				2'b01:   mf_fn = FN_LOCK;
				2'b11:   mf_fn = FN_SWITCH;
				default: mf_fn = FN_NONE;
			endcase
		end
	end

	// position hold is level based: releasing the input returns to speed loop
	always_comb
	begin
		mode = torque_cfg ? MODE_TORQUE : MODE_SPEED;
		if (cfg_q[`SCIS_IX_MODE_CFG][1:0] == `SCIS_MC_TORQUE2 && mf_fn == FN_SWITCH &&
			ctl_s.multi_fn)
		begin
			mode = MODE_SPEED;
		end
		if (mode == MODE_SPEED && mf_fn == FN_LOCK && ctl_s.multi_fn &&
			speed_mag < cfg_q[`SCIS_IX_LOCK_SPEED])
		begin
			mode = MODE_POSITION;
		end
	end

	always_comb
	begin
		cmd_d                  = cmd_q;
		// power needs encoder ready to start, but only the supply to stay on
		cmd_d.main_power       = run_eff & ~alarm_q &
			(cmd_q.main_power ? enc_supply_q : enc_ok);
		cmd_d.integral_disable = (mf_fn == FN_GAIN) & ctl_s.multi_fn;
		cmd_d.ctrl_mode        = mode;
		cmd_d.speed_limit_mode = (mode == MODE_TORQUE);
		cmd_d.internal_speed_direction = (mf_fn == FN_DIRECTION) & ctl_s.multi_fn;
		cmd_d.internal_speed_active    = dir_sel & (spd_code != 2'b00);
		unique case (spd_code)
			2'b01:   cmd_d.internal_speed = cfg_q[`SCIS_IX_SPEED1];
			2'b10:   cmd_d.internal_speed = cfg_q[`SCIS_IX_SPEED2];
			2'b11:   cmd_d.internal_speed = cfg_q[`SCIS_IX_SPEED3];
			default: cmd_d.internal_speed = `SCIS_RST_ZERO;
		endcase
		cmd_d.forward_clamp_on      = ~dir_sel & ctl_s.forward_current_clamp;
		cmd_d.reverse_clamp_on      = ~dir_sel & ctl_s.reverse_current_clamp;
		cmd_d.forward_clamp_percent = cfg_q[`SCIS_IX_FWD_CLAMP];
		cmd_d.reverse_clamp_percent = cfg_q[`SCIS_IX_REV_CLAMP];
		// overtravel only blocks motion; alarm_q is never touched here
		cmd_d.forward_blocked = ~setup1[`SCIS_S1_FWD_OFF] & ~ctl_s.forward_drive_permit;
		cmd_d.reverse_blocked = ~setup1[`SCIS_S1_REV_OFF] & ~ctl_s.reverse_drive_permit;
		cmd_d.stop_method     = {setup1[`SCIS_S1_STOP_C],
			(mode == MODE_TORQUE) ? 1'b0 : setup1[`SCIS_S1_STOP_B],
			setup1[`SCIS_S1_STOP_A]};
		cmd_d.alarm          = alarm_q;
		cmd_d.encoder_supply = enc_supply_q;
		cmd_d.encoder_phase  = enc_st_q;
	end

	// all drive commands leave from one register bank
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cmd_q                       <= '0;
			cmd_q.forward_clamp_percent <= `SCIS_RST_CLAMP;
			cmd_q.reverse_clamp_percent <= `SCIS_RST_CLAMP;
		end
		else
		begin
			cmd_q <= cmd_d;
		end
	end

	assign drive_cmd = cmd_q;

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_enc_rise;
		sen_rise;
	endsequence

	sequence s_enc_cut;
		sen_fall && !cmd_q.main_power;
	endsequence

	sequence s_enc_start;
		s_enc_rise ##1 (enc_st_q == ENC_SERIAL);
	endsequence

	a_sync_two_stage: assert property ((!$past(rst) && !$past(rst, 2)) |-> ctl_s == $past(ctl_in, 2))
		else $error("synchronised inputs do not lag by two cycles");
	a_power_run_gate: assert property (!run_eff |=> !cmd_q.main_power)
		else $error("main power on without run");
	a_power_bypass_on: assert property ((setup1[`SCIS_S1_RUN_BYPASS] && enc_ok && !alarm_q)
		|=> cmd_q.main_power)
		else $error("bypass did not turn servo on");
	a_power_enc_wait: assert property ((!cmd_q.main_power && !enc_ok) |=> !cmd_q.main_power)
		else $error("motor powered before encoder ready");
	a_enc_supply_on: assert property (s_enc_rise |=> enc_supply_q && enc_st_q == ENC_SERIAL)
		else $error("encoder supply not turned on by request");
	a_enc_supply_cut: assert property (s_enc_cut |=> !enc_supply_q && enc_st_q == ENC_OFF)
		else $error("encoder supply not cut");
	a_enc_held_on: assert property (cmd_q.main_power |=> enc_supply_q)
		else $error("encoder supply dropped while powered");
	a_enc_seq_order: assert property (s_enc_start |-> !serial_done && !ready_done)
		else $error("encoder sequence started with stale timers");
	a_enc_normal_late: assert property ((enc_st_q == ENC_NORMAL) |-> ready_done)
		else $error("normal output before ready delay");
	a_alarm_clear_in: assert property ((arst_rise && !drive_fault) |=> !alarm_q)
		else $error("alarm reset ignored");
	a_fwd_block_cfg: assert property ((!setup1[`SCIS_S1_FWD_OFF] && !ctl_s.forward_drive_permit)
		|=> cmd_q.forward_blocked)
		else $error("forward prohibit not honoured");
	a_gain_integral: assert property ((mf_fn == FN_GAIN && ctl_s.multi_fn)
		|=> cmd_q.integral_disable)
		else $error("integral not disabled");
	a_torque_stop_bit: assert property ((mode == MODE_TORQUE) |=> !cmd_q.stop_method[1])
		else $error("stop bit 8 used under torque control");

endmodule
`default_nettype wire

// [scis_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// host controller model
// ----------------------------------------------------------------------------
module scis_host_model #(
	parameter int unsigned HOLD = 30
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire scis_pkg::scis_ctl_in_type want,
	output var scis_pkg::scis_ctl_in_type  ctl_out
);
	import scis_pkg::*;

	int unsigned     age_q;
	scis_ctl_in_type nxt;

	// edges since power-up; the request stays low until it runs out
	always_ff @(posedge clk)
	begin
		if (rst)
			age_q <= 0;
		else if (age_q < HOLD)
			age_q <= age_q + 1;
	end

	// host duties; reset is refused while run is on, to avoid a lurch
	always_comb
	begin
		nxt                       = want;
		nxt.encoder_power_request = want.encoder_power_request && age_q >= HOLD;
		nxt.alarm_reset           = want.alarm_reset && !want.run;
	end

	// launch flop: one assignment per edge
	always_ff @(posedge clk)
	begin
		ctl_out <= nxt;
	end
endmodule

`default_nettype wire

// [servo_control_input_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module servo_control_input_sequencer_bench;
	import scis_pkg::*;

	logic               clk = 0;
	logic               rst = 1;
	logic               psel = 0;
	logic               penable = 0;
	logic               pwrite = 0;
	logic [7:0]         paddr = 0;
	logic [31:0]        pwdata = 0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	scis_ctl_in_type    want = 8'h30;
	scis_ctl_in_type    ctl_in;
	logic               drive_fault = 0;
	logic signed [15:0] motor_speed = 0;
	scis_drive_cmd_type cmd;
	int                 miscompares = 0;
	int                 checks = 0;
	logic [31:0]        rd;
	logic               er;

	// ------------------------------------------------------------------------
	// design and host
	// ------------------------------------------------------------------------
	scis_top #(.ENC_READY_CYCLES(20), .ENC_SERIAL_CYCLES(5)) dut_u (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ctl_in(ctl_in), .drive_fault(drive_fault),
		.motor_speed(motor_speed), .drive_cmd(cmd));
	scis_host_model #(.HOLD(30)) host_u (.clk(clk), .rst(rst), .want(want), .ctl_out(ctl_in));

	// 125 MHz
	always #4 clk = ~clk;

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			$display("mismatch at %0t got %h expected %h", $time, g, e);
			miscompares++;
		end
	endtask

	// one apb transfer; waits on pready, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// inputs take 3 edges to reach the outputs, 4 for alarm reset and encoder request, plus the host flop
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	// a hang counts against the run
	initial
	begin
		#200000;
		miscompares++;
		give_verdict();
	end

	// ------------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 10; i++)
		begin
			apb(0, 8'(i * 4), 32'h0000_0000);
			cmp(rd, (i == 3 || i == 4) ? 32'h0000_0064 : 32'h0000_0000);
		end
		apb(0, 8'h28, 32'h0000_0000);
		cmp({er, rd[30:0]}, 32'h8000_0000);
		// gain reduction, then position lock below and above threshold
		want.multi_fn <= 1;
		settle();
		cmp(cmd.integral_disable, 1);
		apb(1, 8'h08, 32'h0000_000a);
		apb(1, 8'h00, 32'h0000_0400);
		settle();
		cmp(cmd.ctrl_mode, MODE_POSITION);
		cmp(cmd.integral_disable, 0);
		@(posedge clk);
		motor_speed <= 50;
		settle();
		cmp(cmd.ctrl_mode, MODE_SPEED);
		// b,A = 1,0 leaves the multi-function input without effect
		apb(1, 8'h00, 32'h0000_0800);
		settle();
		cmp({cmd.integral_disable, cmd.ctrl_mode}, 3'b000);
		// torque mode II with the switch input
		apb(1, 8'h00, 32'h0000_0c00);
		apb(1, 8'h20, 32'h0000_0002);
		want.multi_fn <= 0;
		settle();
		cmp({cmd.ctrl_mode, cmd.speed_limit_mode}, {MODE_TORQUE, 1'b1});
		want.multi_fn <= 1;
		settle();
		cmp(cmd.ctrl_mode, MODE_SPEED);
		// permits removed, stop method bits 6, 8, 9
		want.forward_drive_permit <= 0;
		want.reverse_drive_permit <= 0;
		apb(1, 8'h00, 32'h0000_0340);
		apb(1, 8'h20, 32'h0000_0000);
		settle();
		cmp({cmd.forward_blocked, cmd.reverse_blocked, cmd.stop_method}, 5'h1f);
		cmp(cmd.alarm, 0);
		apb(1, 8'h20, 32'h0000_0001);
		settle();
		cmp(cmd.stop_method, 3'b101);
		apb(1, 8'h00, 32'h0000_034c);
		settle();
		cmp({cmd.forward_blocked, cmd.reverse_blocked}, 2'b00);
		// current clamps, then speed select with direction
		apb(1, 8'h0c, 32'h0000_0096);
		want.forward_current_clamp <= 1;
		want.reverse_current_clamp <= 1;
		settle();
		cmp({cmd.forward_clamp_on, cmd.reverse_clamp_on}, 2'b11);
		cmp({cmd.forward_clamp_percent, cmd.reverse_clamp_percent}, 32'h0096_0064);
		apb(1, 8'h1c, 32'h0000_0123);
		apb(1, 8'h04, 32'h0000_0004);
		settle();
		cmp({cmd.internal_speed_active, cmd.internal_speed, cmd.forward_clamp_on}, 18'h2_0246);
		cmp(cmd.internal_speed_direction, 1);
		want.multi_fn <= 0;
		settle();
		cmp(cmd.internal_speed_direction, 0);
		// alarm raised by a fault, cleared by the reset input
		@(posedge clk);
		drive_fault <= 1;
		@(posedge clk);
		drive_fault <= 0;
		settle();
		cmp(cmd.alarm, 1);
		want.alarm_reset <= 1;
		settle();
		cmp(cmd.alarm, 0);
		want.alarm_reset <= 0;
		// encoder supply sequence
		want.run <= 1;
		settle();
		cmp(cmd.main_power, 0);
		want.encoder_power_request <= 1;
		settle();
		cmp({cmd.encoder_supply, cmd.encoder_phase, cmd.main_power}, {3'b101, 1'b0});
		repeat (30) @(posedge clk);
		#1;
		cmp({cmd.encoder_phase, cmd.main_power}, 3'b111);
		want.encoder_power_request <= 0;
		settle();
		cmp({cmd.encoder_supply, cmd.main_power}, 2'b11);
		apb(0, 8'h24, 32'h0000_0000);
		cmp(rd[4:0], 5'h1e);
		want.run <= 0;
		settle();
		cmp({cmd.encoder_supply, cmd.main_power}, 2'b10);
		want.encoder_power_request <= 1;
		settle();
		want.encoder_power_request <= 0;
		settle();
		cmp(cmd.encoder_supply, 0);
		// bypass: powered with run off once the encoder is normal
		want.encoder_power_request <= 1;
		apb(1, 8'h00, 32'h0000_0001);
		repeat (40) @(posedge clk);
		#1;
		cmp(cmd.main_power, 1);
		give_verdict();
	end
endmodule

`default_nettype wire
